// [verilog/cms_clock_mode_select.sv]
// cms_clock_mode_select.sv: cpu clock mode selection from reset straps
// assumes straps and crystal input are asynchronous pins; the free-running
// pll and system configuration come from logic on core_clk_in
`include "cms_cfg.svh"
`default_nettype none

module cms_clock_mode_select
  import cms_pkg::*;
(
  input wire logic core_clk_in,                     // system clock
  input wire logic srst_in,                         // sync reset, high
  input wire logic [2:0] clock_mode_straps_in,      // strap pins
  input wire logic crystal_input_pin_in,            // input clock pin
  input wire logic pll_tick_in,                     // free pll cycle
  input wire logic [`CMS_SYSCFG_WIDTH-1:0] system_config_reg_in, // config
  output logic [2:0] clock_mode_out,                // latched straps
  output logic [4:0] pll_mult_out,                  // factor, 0 = div2
  output cms_src_t cpu_clk_src_out,                 // clock source
  output logic pll_enable_out,                      // pll powered
  output logic pll_free_run_out,                    // pll free-running
  output logic osc_amp_bypass_out,                  // amplifier bypassed
  output logic cpu_clk_out,                         // cpu clock level
  output logic cpu_edge_out,                        // cpu clock changed
  output logic osc_fail_out,                        // sticky failure
  output logic osc_irq_out                          // failure request
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [2:0] strap_s1_reg;
  logic [2:0] strap_s2_reg;
  logic xtal_s1_reg;
  logic xtal_s2_reg;
  logic xtal_s3_reg;

  // no reset: straps must be seen while reset is held
  always_ff @(posedge core_clk_in) begin
    strap_s1_reg <= clock_mode_straps_in;
    strap_s2_reg <= strap_s1_reg;
    xtal_s1_reg <= crystal_input_pin_in;
    xtal_s2_reg <= xtal_s1_reg;
    xtal_s3_reg <= xtal_s2_reg;
  end

  logic xtal_edge;
  logic xtal_rise;
  assign xtal_edge = xtal_s2_reg ^ xtal_s3_reg;
  assign xtal_rise = xtal_s2_reg & ~xtal_s3_reg;

  // ****************************************************************
  // strap latch and configuration
  // ****************************************************************
  logic [2:0] strap_reg;
  logic [2:0] strap_next;
  logic wd_dis_reg;
  logic wd_dis_next;

  always_comb begin
    strap_next = strap_reg;
    if (srst_in) begin
      strap_next = strap_s2_reg;
    end
    wd_dis_next = system_config_reg_in[`CMS_WD_DIS_BIT];
  end

  always_ff @(posedge core_clk_in) begin
    strap_reg <= strap_next;
    if (srst_in) begin
      wd_dis_reg <= 1'b0;
    end else begin
      wd_dis_reg <= wd_dis_next;
    end
  end

  // ****************************************************************
  // mode decode
  // ****************************************************************
  logic is_direct;
  logic is_presc;
  logic non_pll;
  logic wd_en;
  logic wd_fail;
  logic wd_irq;
  cms_src_t src;

  assign is_direct = (strap_reg == `CMS_STRAP_DIRECT);
  assign is_presc = (strap_reg == `CMS_STRAP_PRESC);
  assign non_pll = is_direct | is_presc;
  assign wd_en = non_pll & ~wd_dis_reg & ~srst_in;

  always_comb begin
    if (wd_fail) begin
      src = CMS_SRC_FAILOVER;
    end else if (is_direct) begin
      src = CMS_SRC_DIRECT;
    end else if (is_presc) begin
      src = CMS_SRC_PRESC;
    end else begin
      src = CMS_SRC_PLL;
    end
  end

  cms_osc_watchdog u_wd (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .enable_in(wd_en),
    .pll_tick_in(pll_tick_in),
    .xtal_edge_in(xtal_edge),
    .fail_out(wd_fail),
    .irq_out(wd_irq)
  );

  // ****************************************************************
  // cpu clock generation
  // ****************************************************************
  logic cpu_clk_reg;
  logic cpu_clk_next;
  logic cpu_edge_reg;
  logic cpu_edge_next;

  always_comb begin
    cpu_clk_next = cpu_clk_reg;
    case (src)
      CMS_SRC_DIRECT: cpu_clk_next = xtal_s2_reg;
      CMS_SRC_PRESC: begin
        if (xtal_rise) begin
          cpu_clk_next = ~cpu_clk_reg;
        end
      end
      CMS_SRC_PLL, CMS_SRC_FAILOVER: begin
        if (pll_tick_in) begin
          cpu_clk_next = ~cpu_clk_reg;
        end
      end
      default: cpu_clk_next = cpu_clk_reg;
    endcase
    cpu_edge_next = cpu_clk_next ^ cpu_clk_reg;
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      cpu_clk_reg <= 1'b0;
      cpu_edge_reg <= 1'b0;
    end else begin
      cpu_clk_reg <= cpu_clk_next;
      cpu_edge_reg <= cpu_edge_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign clock_mode_out = strap_reg;
  assign pll_mult_out = cms_mult(strap_reg);
  assign cpu_clk_src_out = src;
  assign pll_free_run_out = non_pll & ~wd_dis_reg;
  assign pll_enable_out = ~non_pll | ~wd_dis_reg;
  assign osc_amp_bypass_out = is_direct;
  assign cpu_clk_out = cpu_clk_reg;
  assign cpu_edge_out = cpu_edge_reg;
  assign osc_fail_out = wd_fail;
  assign osc_irq_out = wd_irq;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_in); endclocking

  // wait until the unreset synchroniser has filled before judging it
  strap_sample_a: assert property (
    srst_in && $past(srst_in, 3) |=> strap_reg == $past(strap_s2_reg))
    else $error("straps not sampled during reset");

  strap_hold_a: assert property (
    disable iff (srst_in) !$past(srst_in) |-> $stable(strap_reg))
    else $error("strap latch changed after reset");

  mult_map_a: assert property (
    strap_reg == `CMS_STRAP_X16 |-> pll_mult_out == `CMS_MULT_X16
      && !non_pll && pll_enable_out)
    else $error("x16 code decoded wrongly");

  presc_half_a: assert property (
    disable iff (srst_in)
    src == CMS_SRC_PRESC && xtal_rise |=> cpu_clk_reg != $past(cpu_clk_reg))
    else $error("prescaler did not toggle on input rise");

  presc_hold_a: assert property (
    disable iff (srst_in)
    src == CMS_SRC_PRESC && !xtal_rise ##1 src == CMS_SRC_PRESC
      |-> $stable(cpu_clk_reg))
    else $error("prescaler toggled without input rise");

  direct_follow_a: assert property (
    disable iff (srst_in)
    src == CMS_SRC_DIRECT [*2] |-> cpu_clk_reg == $past(xtal_s2_reg)
      && osc_amp_bypass_out)
    else $error("direct drive not following input");

  direct_period_a: assert property (
    disable iff (srst_in)
    src == CMS_SRC_DIRECT && xtal_edge && !$past(srst_in) |=> cpu_edge_out)
    else $error("input edge lost in direct drive");

  both_edges_a: assert property (
    disable iff (srst_in)
    $changed(cpu_clk_reg) |-> cpu_edge_out ##1 !cpu_edge_out
      || $changed(cpu_clk_reg))
    else $error("cpu edge marker wrong");

  free_run_a: assert property (
    non_pll && !wd_dis_reg |-> pll_enable_out && pll_free_run_out)
    else $error("pll not free-running for watchdog");

  pll_off_a: assert property (
    disable iff (srst_in)
    non_pll && wd_dis_reg |-> !pll_enable_out && !pll_free_run_out
      && !osc_fail_out)
    else $error("pll not switched off");

  wd_reset_a: assert property (
    srst_in |=> !wd_dis_reg)
    else $error("watchdog not enabled by reset");

  failover_a: assert property (
    disable iff (srst_in)
    $rose(wd_fail) |-> src == CMS_SRC_FAILOVER && osc_irq_out)
    else $error("failure did not switch clock source");

  direct_cov_c: cover property (
    disable iff (srst_in) src == CMS_SRC_DIRECT && cpu_edge_out);

  presc_cov_c: cover property (
    disable iff (srst_in) src == CMS_SRC_PRESC && cpu_edge_out);

  fail_cov_c: cover property (
    disable iff (srst_in) osc_irq_out);

  pll_cov_c: cover property (
    disable iff (srst_in) src == CMS_SRC_PLL && pll_mult_out == `CMS_MULT_X10);

endmodule

`default_nettype wire

// [verilog/cms_cfg.svh]
// cms_cfg.svh: constants of the cpu clock mode select block
// assumes inclusion by bare name from package and design modules
`ifndef CMS_CFG_SVH
`define CMS_CFG_SVH

// ****************************************************************
// strap codes
// ****************************************************************
`define CMS_STRAP_X4 3'h7
`define CMS_STRAP_X3 3'h6
`define CMS_STRAP_X8 3'h5
`define CMS_STRAP_X5 3'h4
`define CMS_STRAP_DIRECT 3'h3
`define CMS_STRAP_X10 3'h2
`define CMS_STRAP_PRESC 3'h1
`define CMS_STRAP_X16 3'h0
`define CMS_STRAP_RESET 3'h7

// ****************************************************************
// multiplication factors
// ****************************************************************
`define CMS_MULT_X1 5'h01
`define CMS_MULT_X3 5'h03
`define CMS_MULT_X4 5'h04
`define CMS_MULT_X5 5'h05
`define CMS_MULT_X8 5'h08
`define CMS_MULT_X10 5'h0A
`define CMS_MULT_X16 5'h10
`define CMS_MULT_DIV2 5'h00

// ****************************************************************
// system configuration and watchdog
// ****************************************************************
`define CMS_SYSCFG_WIDTH 16
`define CMS_WD_DIS_BIT 4
`define CMS_WD_LIMIT 5'h10
`define CMS_WD_ZERO 5'h00
`define CMS_WD_ONE 5'h01

`endif

// [verilog/cms_pkg.sv]
// cms_pkg.sv: types and the strap decode of the clock mode select block
// assumes cms_cfg.svh is on the include path
`include "cms_cfg.svh"
`default_nettype none

package cms_pkg;

  typedef enum logic [1:0] {
    CMS_SRC_PLL,
    CMS_SRC_PRESC,
    CMS_SRC_DIRECT,
    CMS_SRC_FAILOVER
  } cms_src_t;

  function automatic logic [4:0] cms_mult(input logic [2:0] straps);
    logic [4:0] m;
    m = `CMS_MULT_X4;
    case (straps)
      `CMS_STRAP_X4: m = `CMS_MULT_X4;
      `CMS_STRAP_X3: m = `CMS_MULT_X3;
      `CMS_STRAP_X8: m = `CMS_MULT_X8;
      `CMS_STRAP_X5: m = `CMS_MULT_X5;
      `CMS_STRAP_DIRECT: m = `CMS_MULT_X1;
      `CMS_STRAP_X10: m = `CMS_MULT_X10;
      `CMS_STRAP_PRESC: m = `CMS_MULT_DIV2;
      `CMS_STRAP_X16: m = `CMS_MULT_X16;
      default: m = `CMS_MULT_X4;
    endcase
    return m;
  endfunction

endpackage

`default_nettype wire

// [verilog/cms_osc_watchdog.sv]
// cms_osc_watchdog.sv: counts free-running pll ticks between input edges
// assumes tick and edge pulses come from logic on core_clk_in
`include "cms_cfg.svh"
`default_nettype none

module cms_osc_watchdog
  import cms_pkg::*;
(
  input wire logic core_clk_in,  // system clock
  input wire logic srst_in,      // sync reset, active high
  input wire logic enable_in,    // watchdog active
  input wire logic pll_tick_in,  // one free-running pll cycle
  input wire logic xtal_edge_in, // input clock transition seen
  output logic fail_out,         // sticky input clock failure
  output logic irq_out           // one-cycle failure request
);

  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic fail_reg;
  logic fail_next;
  logic irq_reg;
  logic irq_next;

  // ****************************************************************
  // counter and failure flag
  // ****************************************************************
  always_comb begin
    cnt_next = cnt_reg;
    fail_next = fail_reg;
    irq_next = 1'b0;
    if (!enable_in || xtal_edge_in) begin
      cnt_next = `CMS_WD_ZERO;
    end else if (pll_tick_in && cnt_reg != `CMS_WD_LIMIT) begin
      cnt_next = cnt_reg + `CMS_WD_ONE;
    end
    if (enable_in && cnt_reg == `CMS_WD_LIMIT && !fail_reg) begin
      fail_next = 1'b1;
      irq_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      cnt_reg <= `CMS_WD_ZERO;
      fail_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      fail_reg <= fail_next;
      irq_reg <= irq_next;
    end
  end

  assign fail_out = fail_reg;
  assign irq_out = irq_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  wd_overflow_a: assert property (
    enable_in && !fail_reg && cnt_reg == `CMS_WD_LIMIT
      |=> fail_reg && irq_reg ##1 fail_reg && !irq_reg)
    else $error("watchdog overflow did not flag failure");

  wd_clear_a: assert property (
    enable_in && xtal_edge_in |=> cnt_reg == `CMS_WD_ZERO)
    else $error("watchdog counter not cleared on input edge");

  wd_sticky_a: assert property (
    fail_reg |=> fail_reg)
    else $error("failure flag dropped without reset");

endmodule

`default_nettype wire

// [sim/cms_board_model.sv]
// cms_board_model.sv: board side of the clock mode select block
// assumes strap codes and crystal timing are commanded by the bench
`default_nettype none

module cms_board_model (
  input wire logic clk_in,              // bench clock
  input wire logic [2:0] strap_code_in, // strap levels to present
  input wire logic xtal_run_in,         // crystal oscillating
  input wire logic [7:0] xtal_half_in,  // half period in clock cycles
  output logic [2:0] straps_out,        // strap pins
  output logic xtal_out                 // crystal input pin
);
  timeunit 1ns;
  timeprecision 1ps;

  int half_cnt = 0;
  logic xtal_lvl = 1'b0;

  assign straps_out = strap_code_in;
  assign xtal_out = xtal_lvl;

  // a stopped crystal freezes at its last level, like a dead oscillator

  always @(posedge clk_in) begin
    #1;
    if (xtal_run_in) begin
      half_cnt = half_cnt + 1;
      if (half_cnt >= xtal_half_in) begin
        half_cnt = 0;
        xtal_lvl = ~xtal_lvl;
      end
    end
  end
endmodule

`default_nettype wire

// [sim/test_cpu_clock_mode_select.sv]
// test_cpu_clock_mode_select.sv: self-checking bench of the mode select
// assumes design files and cms_cfg.svh are compiled first
`include "cms_cfg.svh"
`default_nettype none

module test_cpu_clock_mode_select;
  timeunit 1ns;
  timeprecision 1ps;
  import cms_pkg::*;

  logic core_clk, srst, xtal_run, pll_tick, prev_clk;
  logic [2:0] strap_code;
  logic [7:0] xtal_half;
  logic [15:0] syscfg;
  logic [2:0] straps, mode;
  logic xtal, pll_en, free_run, bypass, cpu_clk, cpu_edge, fail, irq;
  logic [4:0] mult;
  cms_src_t src;
  int num_errors, n_checks, cycles, tick_per, tick_cnt;
  int n_bad, n_irq, rise_at, rise_int, lat;

  cms_board_model i_board (.clk_in(core_clk), .strap_code_in(strap_code),
    .xtal_run_in(xtal_run), .xtal_half_in(xtal_half),
    .straps_out(straps), .xtal_out(xtal));

  cms_clock_mode_select i_dut (.core_clk_in(core_clk), .srst_in(srst),
    .clock_mode_straps_in(straps), .crystal_input_pin_in(xtal),
    .pll_tick_in(pll_tick), .system_config_reg_in(syscfg),
    .clock_mode_out(mode), .pll_mult_out(mult), .cpu_clk_src_out(src),
    .pll_enable_out(pll_en), .pll_free_run_out(free_run),
    .osc_amp_bypass_out(bypass), .cpu_clk_out(cpu_clk),
    .cpu_edge_out(cpu_edge), .osc_fail_out(fail), .osc_irq_out(irq));

  // ****************************************************************
  // clock, pll ticks, monitor, timeout
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    #1;
    tick_cnt = (tick_cnt + 1 >= tick_per) ? 0 : tick_cnt + 1;
    pll_tick = (tick_per != 0) && (tick_cnt == 0);
  end

  always @(posedge core_clk) begin
    #2;
    cycles = cycles + 1;
    if (cpu_edge !== (cpu_clk !== prev_clk)) n_bad = n_bad + 1;
    if (cpu_clk === 1'b1 && prev_clk === 1'b0) begin
      rise_int = cycles - rise_at;
      rise_at = cycles;
    end
    if (irq === 1'b1) n_irq = n_irq + 1;
    prev_clk = cpu_clk;
    if (cycles == 5000) begin
      num_errors = num_errors + 1;
      report_and_stop();
    end
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk_val(input logic [4:0] got, input logic [4:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    n_checks = n_checks + 1;
    if (got != exp) begin
      num_errors = num_errors + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input logic [2:0] code, input logic dis);
    @(posedge core_clk);
    #1;
    srst = 1'b1;
    strap_code = code;
    syscfg = 16'h0000;
    syscfg[`CMS_WD_DIS_BIT] = dis;
    repeat (16) @(posedge core_clk);
    #1 srst = 1'b0;
    repeat (4) @(posedge core_clk);
    #3;
    n_bad = 0;
    n_irq = 0;
    rise_int = 0;
  endtask

  function automatic logic [4:0] exp_mult(input logic [2:0] c);
    case (c)
      3'h0: return 5'h10;
      3'h1: return 5'h00;
      3'h2: return 5'h0A;
      3'h3: return 5'h01;
      3'h4: return 5'h05;
      3'h5: return 5'h08;
      3'h6: return 5'h03;
      default: return 5'h04;
    endcase
  endfunction

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic test_decode;
    logic [2:0] c;
    cms_src_t s;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      s = (c == 3'h1) ? CMS_SRC_PRESC : (c == 3'h3) ? CMS_SRC_DIRECT :
          CMS_SRC_PLL;
      do_reset(c, 1'b0);
      chk_val({2'h0, mode}, {2'h0, c});
      chk_val(mult, exp_mult(c));
      chk_val(5'(src), 5'(s));
      chk_val({4'h0, bypass}, {4'h0, c == 3'h3});
      chk_val({4'h0, pll_en}, 5'h01);
      if (s != CMS_SRC_PLL) begin
        chk_val({4'h0, free_run}, 5'h01);
        do_reset(c, 1'b1);
        chk_val({3'h0, pll_en, free_run}, 5'h00);
      end
    end
    $display("test decode done, errors %0d", num_errors);
  endtask

  task automatic test_clocks;
    xtal_half = 8'h05;
    do_reset(3'h3, 1'b0);
    @(posedge core_clk);
    #1 strap_code = 3'h0;
    repeat (59) @(posedge core_clk);
    #3;
    chk_cnt(rise_int, 10);
    chk_cnt(n_bad, 0);
    chk_val({2'h0, mode}, 5'h03);
    chk_val({4'h0, fail}, 5'h00);
    xtal_half = 8'h03;
    do_reset(3'h1, 1'b0);
    repeat (60) @(posedge core_clk);
    #3;
    chk_cnt(rise_int, 12);
    chk_cnt(n_bad, 0);
    tick_per = 4;
    xtal_run = 1'b0;
    do_reset(3'h5, 1'b0);
    repeat (60) @(posedge core_clk);
    #3;
    chk_cnt(rise_int, 8);
    chk_val({4'h0, fail}, 5'h00);
    $display("test clocks done, errors %0d", num_errors);
  endtask

  task automatic test_watchdog;
    tick_per = 0;
    xtal_run = 1'b1;
    do_reset(3'h1, 1'b0);
    xtal_run = 1'b0;
    repeat (8) @(posedge core_clk);
    #3 tick_per = 1;
    lat = 0;
    while (fail !== 1'b1 && lat < 40) begin
      @(posedge core_clk);
      #3 lat = lat + 1;
    end
    chk_cnt(lat, 18);
    xtal_run = 1'b1;
    repeat (30) @(posedge core_clk);
    #3;
    chk_cnt(n_irq, 1);
    chk_val({4'h0, fail}, 5'h01);
    chk_val(5'(src), 5'(CMS_SRC_FAILOVER));
    do_reset(3'h1, 1'b0);
    chk_val({4'h0, fail}, 5'h00);
    chk_val(5'(src), 5'(CMS_SRC_PRESC));
    xtal_run = 1'b0;
    do_reset(3'h3, 1'b1);
    repeat (40) @(posedge core_clk);
    #3;
    chk_val({3'h0, fail, irq}, 5'h00);
    $display("test watchdog done, errors %0d", num_errors);
  endtask

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    srst = 1'b1;
    strap_code = 3'h7;
    xtal_run = 1'b1;
    xtal_half = 8'h04;
    syscfg = 16'h0000;
    pll_tick = 1'b0;
    prev_clk = 1'b0;
    tick_per = 1;
    tick_cnt = 0;
    num_errors = 0;
    n_checks = 0;
    cycles = 0;
    rise_at = 0;
    test_decode();
    test_clocks();
    test_watchdog();
    report_and_stop();
  end
endmodule

`default_nettype wire
